// ---- logic/drjss_regs.vh ----
// Constants for the drive run/jog/stop sequencer
// Assumes inclusion by plain Verilog-2005 design files
`ifndef DRJSS_REGS_VH
`define DRJSS_REGS_VH

`define DRJSS_STOP_COAST     2'h0
`define DRJSS_STOP_RAMP      2'h1
`define DRJSS_STOP_CLIM      2'h2
`define DRJSS_STOP_RSVD      2'h3

`define DRJSS_SPD_W          16
`define DRJSS_DLY_W          16

`define DRJSS_DECEL_NORMAL   1'b0
`define DRJSS_DECEL_RAMPSTOP 1'b1

`define DRJSS_REF_HOLD       2'h0
`define DRJSS_REF_RUN        2'h1
`define DRJSS_REF_JOG        2'h2

`endif

// ---- logic/drjss_jog_off_timer.v ----
// Jog-off qualification: delay count and speed threshold
// Assumes synchronous inputs on sys_clk_i
`timescale 1ns/10ps
`include "drjss_regs.vh"

module drjss_jog_off_timer (
  // Clock and reset
  input  wire                     sys_clk_i,
  input  wire                     rst_i,
  // Control
  input  wire                     arm_i,
  input  wire [`DRJSS_DLY_W-1:0]  delay_cycles_i,
  input  wire                     at_stop_speed_i,
  // Result
  output reg                      jog_off_ok_o
);

  reg [`DRJSS_DLY_W-1:0] cnt_reg;
  reg                    expired_reg;

  always @(posedge sys_clk_i) begin
    if (rst_i || !arm_i) begin
      cnt_reg      <= {`DRJSS_DLY_W{1'b0}};
      expired_reg  <= 1'b0;
      jog_off_ok_o <= 1'b0;
    end else begin
      if (cnt_reg >= delay_cycles_i)
        expired_reg <= 1'b1;
      else
        cnt_reg <= cnt_reg + {{(`DRJSS_DLY_W-1){1'b0}}, 1'b1};
      jog_off_ok_o <= expired_reg && at_stop_speed_i;
    end
  end

endmodule // drjss_jog_off_timer

// ---- logic/drjss_sequencer.v ----
// Drive run/jog/stop sequencer top level
// Assumes all command, feedback and setting inputs come from off-clock pins
// Operation
// - exactly one of inactive, run, jog
// - run input starts run until stop completes
// - jog starts jog; run moves jog to run
// - jog ignored in run; jog only after stop
// - jog to run ramps with accel/decel time
// - jog release waits speed threshold and delay
// - run, or jog in a stop begun from jog, aborts ramp/current-limit stop
// - coast-with-braking stop always completes
// - coast stop on setting, interlock, or fault
// - coast: small firing, discontinuous, swap contactors
// - run ramp stop needs stop, setting, run
// - run ramp: zero to S-curve, chosen decel
// - wait speed, zero current, discontinuous, contactors
// - jog ramp stop needs setting, jog, release, qualified; code starts it on qualified release for any stop code
// - jog stops ramp jog reference at jog rate
// - current-limit stop from run or jog release
// - run current-limit: zero at summing junction
`timescale 1ns/10ps
`include "drjss_regs.vh"

module drjss_sequencer (
  // Clock and reset
  input  wire                     sys_clk_i,
  input  wire                     rst_i,
  // Operator commands
  input  wire                     run_i,
  input  wire                     jog_i,
  input  wire                     stop_i,
  input  wire                     coast_interlock_ok_i,
  input  wire                     customer_interlock_ok_i,
  input  wire                     fault_i,
  // Settings
  input  wire [1:0]               stop_mode_i,
  input  wire                     stop_decel_sel_i,
  input  wire [`DRJSS_DLY_W-1:0]  jog_off_delay_i,
  // Feedback
  input  wire                     at_stop_speed_i,
  input  wire                     discontinuous_i,
  // Power side
  output reg                      main_contactor_o,
  output reg                      dynamic_braking_contactor_o,
  output reg                      firing_min_o,
  output reg                      current_ref_zero_o,
  output reg                      scurve_zero_o,
  output reg                      jog_ramp_zero_o,
  output reg                      speed_sum_zero_o,
  output reg                      use_rampstop_decel_o,
  output reg [1:0]                ref_select_o,
  // Status
  output reg                      run_mode_o,
  output reg                      jog_mode_o,
  output reg                      stopping_o
);

  localparam ST_IDLE     = 4'h0;
  localparam ST_RUN      = 4'h1;
  localparam ST_JOG      = 4'h2;
  localparam ST_JOG_REL  = 4'h3;
  localparam ST_COAST    = 4'h4;
  localparam ST_RAMP_SPD = 4'h5;
  localparam ST_RAMP_DIS = 4'h6;
  localparam ST_OPEN     = 4'h7;

  // Input synchronisers
  reg [7:0] sy1_reg;
  reg [7:0] sy2_reg;
  reg       spd1_reg;
  reg       spd2_reg;
  reg       dis1_reg;
  reg       dis2_reg;
  reg [1:0] mode1_reg;
  reg [1:0] mode2_reg;
  reg       dsel1_reg;
  reg       dsel2_reg;
  reg [`DRJSS_DLY_W-1:0] dly1_reg;
  reg [`DRJSS_DLY_W-1:0] dly2_reg;

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      sy1_reg   <= 8'h00;
      sy2_reg   <= 8'h00;
      spd1_reg  <= 1'b0;
      spd2_reg  <= 1'b0;
      dis1_reg  <= 1'b0;
      dis2_reg  <= 1'b0;
      mode1_reg <= 2'h0;
      mode2_reg <= 2'h0;
      dsel1_reg <= 1'b0;
      dsel2_reg <= 1'b0;
    end else begin
      sy1_reg   <= {run_i, 2'h0, fault_i, customer_interlock_ok_i, coast_interlock_ok_i, stop_i, jog_i};
      sy2_reg   <= sy1_reg;
      spd1_reg  <= at_stop_speed_i;
      spd2_reg  <= spd1_reg;
      dis1_reg  <= discontinuous_i;
      dis2_reg  <= dis1_reg;
      mode1_reg <= stop_mode_i;
      mode2_reg <= mode1_reg;
      dsel1_reg <= stop_decel_sel_i;
      dsel2_reg <= dsel1_reg;
    end
  end

  // Jog-off delay setting synchroniser; the setting is held static while used
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      dly1_reg <= {`DRJSS_DLY_W{1'b0}};
      dly2_reg <= {`DRJSS_DLY_W{1'b0}};
    end else begin
      dly1_reg <= jog_off_delay_i;
      dly2_reg <= dly1_reg;
    end
  end

  wire run_s    = sy2_reg[7];
  wire jog_s    = sy2_reg[0];
  wire stop_s   = sy2_reg[1];
  wire perm_ok  = sy2_reg[2] & sy2_reg[3];
  wire fault_s  = sy2_reg[4];

  // Stop code decode; unused code falls to coast
  function is_coast;
    input [1:0] m;
    begin
      is_coast = (m == `DRJSS_STOP_COAST) || (m == `DRJSS_STOP_RSVD);
    end
  endfunction

  // Current-limit stop selected by the stop code
  function is_clim;
    input [1:0] m;
    begin
      is_clim = (m == `DRJSS_STOP_CLIM);
    end
  endfunction

  // Ramp or current-limit stop phases
  function in_stop_wait;
    input [3:0] s;
    begin
      in_stop_wait = (s == ST_RAMP_SPD) || (s == ST_RAMP_DIS);
    end
  endfunction

  // Jogging, with or without the jog input held
  function in_jog;
    input [3:0] s;
    begin
      in_jog = (s == ST_JOG) || (s == ST_JOG_REL);
    end
  endfunction

  // Main contactor open: idle or the opening cycle
  function in_open;
    input [3:0] s;
    begin
      in_open = (s == ST_IDLE) || (s == ST_OPEN);
    end
  endfunction

  // Any phase of a stop sequence
  function in_stop;
    input [3:0] s;
    begin
      in_stop = in_stop_wait(s) || (s == ST_COAST) || (s == ST_OPEN);
    end
  endfunction

  reg  [3:0] state_reg;
  reg  [3:0] state_next;
  reg        from_jog_reg;
  reg        from_jog_next;
  reg        clim_reg;
  reg        clim_next;
  wire       jog_off_ok;

  drjss_jog_off_timer u_jog_off (
    .sys_clk_i       (sys_clk_i),
    .rst_i           (rst_i),
    .arm_i           (state_reg == ST_JOG_REL),
    .delay_cycles_i  (dly2_reg),
    .at_stop_speed_i (spd2_reg),
    .jog_off_ok_o    (jog_off_ok)
  );

  wire coast_req = (stop_s && is_coast(mode2_reg)) || !perm_ok || fault_s;

  always @* begin
    state_next    = state_reg;
    from_jog_next = from_jog_reg;
    clim_next     = clim_reg;
    case (state_reg)
      ST_IDLE: begin
        if (coast_req)
          state_next = ST_IDLE;
        else if (run_s) begin
          state_next    = ST_RUN;
          from_jog_next = 1'b0;
        end else if (jog_s) begin
          state_next    = ST_JOG;
          from_jog_next = 1'b1;
        end
      end
      ST_RUN: begin
        if (coast_req)
          state_next = ST_COAST;
        else if (stop_s) begin
          state_next    = ST_RAMP_SPD;
          from_jog_next = 1'b0;
          clim_next     = is_clim(mode2_reg);
        end
      end
      ST_JOG, ST_JOG_REL: begin
        if (coast_req)
          state_next = ST_COAST;
        else if (run_s) begin
          state_next    = ST_RUN;
          from_jog_next = 1'b0;
        end else if (jog_s)
          state_next = ST_JOG;
        else if (state_reg == ST_JOG)
          state_next = ST_JOG_REL;
        else if (jog_off_ok) begin
          state_next    = ST_RAMP_SPD;
          from_jog_next = 1'b1;
          clim_next     = is_clim(mode2_reg);
        end
      end
      ST_RAMP_SPD, ST_RAMP_DIS: begin
        if (coast_req)
          state_next = ST_COAST;
        else if (run_s && !stop_s) begin
          state_next    = ST_RUN;
          from_jog_next = 1'b0;
        end else if (jog_s && !stop_s && from_jog_reg)
          state_next = ST_JOG;
        else if (state_reg == ST_RAMP_SPD) begin
          if (spd2_reg)
            state_next = ST_RAMP_DIS;
        end else if (dis2_reg)
          state_next = ST_OPEN;
      end
      ST_COAST: begin
        if (dis2_reg)
          state_next = ST_OPEN;
      end
      ST_OPEN: state_next = ST_IDLE;
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_reg    <= ST_IDLE;
      from_jog_reg <= 1'b0;
      clim_reg     <= 1'b0;
    end else begin
      state_reg    <= state_next;
      from_jog_reg <= from_jog_next;
      clim_reg     <= clim_next;
    end
  end

  // Next-state decode shared by the output registers
  wire nx_wait  = in_stop_wait(state_next);
  wire nx_jog   = in_jog(state_next);
  wire nx_open  = in_open(state_next);
  wire nx_coast = (state_next == ST_COAST);
  wire nx_run   = (state_next == ST_RUN);

  // Registered outputs derived from next state
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      main_contactor_o            <= 1'b0;
      dynamic_braking_contactor_o <= 1'b1;
      firing_min_o                <= 1'b0;
      current_ref_zero_o          <= 1'b1;
      scurve_zero_o               <= 1'b0;
      jog_ramp_zero_o             <= 1'b0;
      speed_sum_zero_o            <= 1'b0;
      use_rampstop_decel_o        <= 1'b0;
      ref_select_o                <= `DRJSS_REF_HOLD;
      run_mode_o                  <= 1'b0;
      jog_mode_o                  <= 1'b0;
      stopping_o                  <= 1'b0;
    end else begin
      main_contactor_o            <= !nx_open;
      dynamic_braking_contactor_o <= nx_open;
      firing_min_o                <= nx_coast;
      current_ref_zero_o          <= (state_next == ST_RAMP_DIS) || nx_open || nx_coast;
      scurve_zero_o               <= (state_next == ST_RAMP_SPD) && !from_jog_next && !clim_next;
      jog_ramp_zero_o             <= (state_next == ST_RAMP_SPD) && from_jog_next;
      speed_sum_zero_o            <= (state_next == ST_RAMP_SPD) && !from_jog_next && clim_next;
      use_rampstop_decel_o        <= (dsel2_reg == `DRJSS_DECEL_RAMPSTOP) && (state_next == ST_RAMP_SPD);
      ref_select_o                <= nx_run ? `DRJSS_REF_RUN :
                                     nx_jog ? `DRJSS_REF_JOG : `DRJSS_REF_HOLD;
      run_mode_o                  <= nx_run || ((nx_wait || nx_coast) && !from_jog_next);
      jog_mode_o                  <= nx_jog || ((nx_wait || nx_coast) && from_jog_next);
      stopping_o                  <= in_stop(state_next);
    end
  end

endmodule // drjss_sequencer

// ---- testbench/drjss_plant.sv ----
// Power-side model: speed decay and armature conduction feedback
// Assumes the sequencer outputs and jog pin share sys_clk_i
`timescale 1ns/10ps
module drjss_plant #(parameter SPD = 20) (
  // Clock, reset and commands
  input  wire sys_clk_i, rst_i, jog_i, run_mode_i, jog_mode_i,
  // Sequencer outputs
  input  wire main_i, zero_i, curz_i,
  // Feedback
  output wire at_stop_speed_o, discontinuous_o
);
  reg  [7:0] spd_reg;
  reg  [1:0] dc_reg;
  wire       drive = main_i & ~zero_i & (run_mode_i | (jog_mode_i & jog_i));
  always @(posedge sys_clk_i) begin
    if (rst_i) spd_reg <= 8'h00;
    else if (drive) spd_reg <= SPD;
    else if (spd_reg != 8'h00) spd_reg <= spd_reg - 8'h01;
    dc_reg <= (curz_i & main_i) ? dc_reg + {1'b0, ~&dc_reg} : 2'h0;
  end
  assign at_stop_speed_o = spd_reg == 8'h00;
  assign discontinuous_o = ~main_i | &dc_reg;
endmodule // drjss_plant

// ---- testbench/drjss_sequencer_monitor.sv ----
// Concurrent checks on the sequencer ports
// Assumes one clock domain and synchronous active-high reset
`timescale 1ns/10ps
module drjss_sequencer_monitor (
  input logic sys_clk_i, rst_i, fault_i, main_contactor_o, dynamic_braking_contactor_o,
  input logic firing_min_o, current_ref_zero_o, scurve_zero_o, jog_ramp_zero_o, speed_sum_zero_o,
  input logic [1:0] ref_select_o,
  input logic run_mode_o, jog_mode_o, stopping_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  one_mode_a: assert property (!(run_mode_o && jog_mode_o)) else $error("run and jog together");
  run_hold_a: assert property ($fell(run_mode_o) |-> $past(stopping_o) && !main_contactor_o)
    else $error("run left without stop");
  jog_run_a: assert property (jog_mode_o ##1 run_mode_o |-> ref_select_o == 2'h1)
    else $error("run reference not selected");
  no_jog_a: assert property (run_mode_o |=> !jog_mode_o) else $error("jog entered from run");
  coast_fault_a: assert property (fault_i [*5] |-> firing_min_o || !main_contactor_o)
    else $error("fault without coast");
  coast_hold_a: assert property (firing_min_o && main_contactor_o |=> firing_min_o || !main_contactor_o)
    else $error("coast stop aborted");
  swap_order_a: assert property ($fell(main_contactor_o) |-> dynamic_braking_contactor_o && $past(current_ref_zero_o))
    else $error("contactor swap out of order");
  ramp_path_a: assert property (scurve_zero_o |-> run_mode_o && stopping_o && !speed_sum_zero_o)
    else $error("ramp zero outside run stop");
  jog_zero_a: assert property (jog_ramp_zero_o |-> jog_mode_o && stopping_o)
    else $error("jog zero outside jog stop");
  sum_zero_a: assert property (speed_sum_zero_o |-> run_mode_o && stopping_o)
    else $error("summing zero outside run stop");
  run_cov: cover property ($rose(run_mode_o));
  coast_cov: cover property ($rose(firing_min_o));
  jog_cov: cover property ($rose(jog_ramp_zero_o));
endmodule // drjss_sequencer_monitor
bind drjss_sequencer drjss_sequencer_monitor drjss_sequencer_monitor_i (.sys_clk_i, .rst_i, .fault_i,
  .main_contactor_o, .dynamic_braking_contactor_o, .firing_min_o, .current_ref_zero_o, .scurve_zero_o,
  .jog_ramp_zero_o, .speed_sum_zero_o, .ref_select_o, .run_mode_o, .jog_mode_o, .stopping_o);

// ---- testbench/drjss_sequencer_tb.sv ----
// Self-checking bench for the run/jog/stop sequencer
// Assumes the power-side model closes speed and conduction feedback
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module drjss_sequencer_tb;
  reg        sys_clk_i = 1'b0, rst_i = 1'b1, run_i = 1'b0, jog_i = 1'b0, stop_i = 1'b0, fault_i = 1'b0;
  reg        ilk = 1'b1, dsel = 1'b0;
  reg [15:0] dly = 16'h0004;
  reg  [1:0] stop_mode_i = 2'h1;
  wire       at_spd, disc, main, brk, firm, curz, scz, jrz, ssz, usr, rm, jm, stp;
  wire [1:0] rsel;
  integer    error_cnt = 0, total_checks = 0, k, m;
  always #5 sys_clk_i = ~sys_clk_i;
  drjss_sequencer drjss_sequencer_i (.sys_clk_i, .rst_i, .run_i, .jog_i, .stop_i, .coast_interlock_ok_i(ilk),
    .customer_interlock_ok_i(ilk), .fault_i, .stop_mode_i, .stop_decel_sel_i(dsel), .jog_off_delay_i(dly),
    .at_stop_speed_i(at_spd), .discontinuous_i(disc), .main_contactor_o(main), .dynamic_braking_contactor_o(brk),
    .firing_min_o(firm), .current_ref_zero_o(curz), .scurve_zero_o(scz), .jog_ramp_zero_o(jrz),
    .speed_sum_zero_o(ssz), .use_rampstop_decel_o(usr), .ref_select_o(rsel), .run_mode_o(rm), .jog_mode_o(jm),
    .stopping_o(stp));
  drjss_plant drjss_plant_i (.sys_clk_i, .rst_i, .jog_i, .run_mode_i(rm), .jog_mode_i(jm), .main_i(main),
    .zero_i(scz | jrz | ssz | firm | curz), .curz_i(curz | firm), .at_stop_speed_o(at_spd), .discontinuous_o(disc));
  task cyc(input integer n); begin repeat (n) @(posedge sys_clk_i); #1; end endtask
  task idle; begin
    for (k = 0; k < 300 && (main || stp); k++) cyc(1);
    stop_i = 1'b0; fault_i = 1'b0; ilk = 1'b1; cyc(4);
    `CHK("main", 1'b0, main)
    `CHK("brake", 1'b1, brk)
    `CHK("run_mode", 1'b0, rm)
  end endtask
  task end_sim; begin
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  end endtask
  initial begin #300000; error_cnt++; end_sim; end
  initial begin
    cyc(10); rst_i = 1'b0; cyc(2);
    run_i = 1'b1; cyc(1); run_i = 1'b0; cyc(4);
    `CHK("run_mode", 1'b1, rm)
    `CHK("ref_sel", 2'h1, rsel)
    jog_i = 1'b1; cyc(6);
    `CHK("jog_mode", 1'b0, jm)
    jog_i = 1'b0; dsel = 1'b1; stop_i = 1'b1; cyc(5);
    `CHK("scurve_zero", 1'b1, scz)
    `CHK("rampstop_decel", 1'b1, usr)
    `CHK("cur_zero", 1'b0, curz)
    for (k = 0; k < 100 && !curz; k++) cyc(1);
    `CHK("main", 1'b1, main)
    `CHK("brake", 1'b0, brk)
    idle; $display("test 1 done");
    jog_i = 1'b1; cyc(5);
    `CHK("jog_mode", 1'b1, jm)
    `CHK("ref_sel", 2'h2, rsel)
    run_i = 1'b1; cyc(5); run_i = 1'b0; jog_i = 1'b0; cyc(4);
    `CHK("run_mode", 1'b1, rm)
    `CHK("ref_sel", 2'h1, rsel)
    stop_mode_i = 2'h2; stop_i = 1'b1; cyc(5);
    `CHK("sum_zero", 1'b1, ssz)
    `CHK("scurve_zero", 1'b0, scz)
    stop_i = 1'b0; run_i = 1'b1; cyc(5); run_i = 1'b0;
    `CHK("stopping", 1'b0, stp)
    ilk = 1'b0; cyc(5);
    `CHK("firing_min", 1'b1, firm)
    run_i = 1'b1; cyc(3); run_i = 1'b0;
    `CHK("firing_min", 1'b1, firm)
    idle; $display("test 2 done");
    for (m = 1; m < 3; m++) begin
      dly = (m == 2) ? 16'h0030 : 16'h0004;
      stop_mode_i = m[1:0]; jog_i = 1'b1; cyc(5); jog_i = 1'b0; cyc(4 + 30 * (m - 1));
      `CHK("stopping", 1'b0, stp)
      for (k = 0; k < 100 && !stp; k++) cyc(1);
      `CHK("jog_zero", 1'b1, jrz)
      idle;
    end
    $display("test 3 done");
    for (m = 0; m < 3; m++) begin
      run_i = 1'b1; cyc(1); run_i = 1'b0; cyc(4);
      stop_mode_i = (m == 1) ? 2'h3 : 2'h0; stop_i = m < 2; fault_i = m == 2; cyc(5);
      `CHK("firing_min", 1'b1, firm)
      idle;
    end
    $display("test 4 done");
    end_sim;
  end
endmodule // drjss_sequencer_tb
